// *** rtl/ssf_pkg.sv ***
package ssf_pkg;
  // register offsets
  localparam logic [7:0] MEAS_DETAIL_ADDR = 8'h90;
  localparam logic [7:0] THRESH_CAUSE_ADDR = 8'h91;
  localparam logic [7:0] MAIN_EVENT_ADDR = 8'h93;
  localparam logic [7:0] SYS_EVENT_ADDR = 8'hBB;
  // main event status bit positions
  localparam int SAT_BIT = 7;
  localparam int SPEC_BIT = 3;
  localparam int QUEUE_BIT = 2;
  localparam int SYS_BIT = 0;
  localparam logic [7:0] MAIN_MASK = 8'h8D;
  // measurement detail bit positions
  localparam int VALID_BIT = 6;
  localparam int CNT_SAT_BIT = 4;
  localparam int FE_SAT_BIT = 3;
  // threshold cause bit positions
  localparam int HIGH_BIT = 5;
  localparam int LOW_BIT = 4;
  // system event bit position
  localparam int SENSOR_SWITCH_MATRIX_BIT = 2;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam int CH_W = 16;
  localparam int PERS_W = 4;
  localparam int LVL_W = 8;

  // one measurement result from the analog path
  typedef struct packed {
    logic done;
    logic [CH_W-1:0] value;
    logic counter_saturation;
    logic frontend_saturation;
  } ssf_meas_t;

  // interrupt enables and thresholds from the configuration bank
  typedef struct packed {
    logic saturation_irq_enable;
    logic spectral_irq_enable;
    logic queue_irq_enable;
    logic system_irq_enable;
    logic [CH_W-1:0] low_threshold;
    logic [CH_W-1:0] high_threshold;
    logic [PERS_W-1:0] persistence_count;
    logic [LVL_W-1:0] queue_threshold;
  } ssf_cfg_t;
endpackage : ssf_pkg

// *** rtl/ssf_flag_bank.sv ***
// Behaviour
// [RULE1] writing one to a main status flag clears it
// [RULE2] writing zero to a set main status flag leaves it set
// [RULE3] host reads, services, then writes back the read value
// [RULE4] host discards saturated data and lowers gain or integration time
// [RULE5] saturation sets main bit 7 when saturation enable is on
// [RULE6] threshold event with persistence sets main bit 3 when enabled
// [RULE7] queue level meeting threshold sets main bit 2 when enabled
// [RULE8] queue flag reasserts as data grows; stays clear once queue empty
// [RULE9] system event sets main bit 0 when system enable is on
// [RULE10] detail bit 6 reads one after a measurement completes
// [RULE11] detail bit 4 set when integration counter saturates
// [RULE12] detail bit 3 set when analog front end saturates
// [RULE13] cause bit 5 set when data rose above high threshold
// [RULE14] cause bit 4 set when data fell below low threshold
// [RULE15] system bit 2 set when switch matrix command finishes
// [RULE16] threshold event needs value outside window for persistence count measurements
// [RULE17] all flags and reserved bits reset to zero, reserved read zero
`timescale 1ns/1ps
module ssf_flag_bank (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // measurement path and configuration
  input wire ssf_pkg::ssf_meas_t meas,
  input wire ssf_pkg::ssf_cfg_t cfg,
  // queue and switch matrix
  input wire logic [ssf_pkg::LVL_W-1:0] queue_fill_level,
  input wire logic switch_matrix_done
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] main_event_status;
  logic [7:0] measurement_detail_status;
  logic [7:0] threshold_cause_status;
  logic [7:0] system_event_status;
  logic [ssf_pkg::PERS_W-1:0] pers_run;
  logic [ssf_pkg::LVL_W-1:0] prev_fill;
  logic prev_queue_cond;

  wire main_wr = reg_wr && (reg_addr == ssf_pkg::MAIN_EVENT_ADDR);
  wire [7:0] clr_mask = main_wr ? (reg_wdata & ssf_pkg::MAIN_MASK) : 8'h00; // RULE1 RULE2
  wire above = meas.value > cfg.high_threshold;
  wire below = meas.value < cfg.low_threshold;
  wire outside = above || below;
  // zero persistence treated as one so any out-of-window result counts
  wire [ssf_pkg::PERS_W-1:0] pers_goal =
    (cfg.persistence_count == 4'h0) ? 4'h1 : cfg.persistence_count;
  wire [ssf_pkg::PERS_W-1:0] pers_inc =
    (pers_run == 4'hF) ? pers_run : 4'(pers_run + 4'h1);
  wire spec_hit = meas.done && outside && (pers_inc >= pers_goal); // RULE16
  wire sat_evt = meas.done && (meas.counter_saturation || meas.frontend_saturation);
  wire queue_cond = (queue_fill_level != 8'h00) && (queue_fill_level >= cfg.queue_threshold);
  // retrigger on fresh data only, so a write-one clear sticks while the level is idle
  wire queue_evt = queue_cond && (!prev_queue_cond || (queue_fill_level > prev_fill)); // RULE8

  wire [7:0] set_mask = {
    sat_evt && cfg.saturation_irq_enable, // RULE5
    3'b000,
    spec_hit && cfg.spectral_irq_enable, // RULE6
    queue_evt && cfg.queue_irq_enable, // RULE7
    1'b0,
    switch_matrix_done && cfg.system_irq_enable // RULE9
  };
  // set wins over a clear in the same cycle
  wire [7:0] next_main = (main_event_status & ~clr_mask) | set_mask; // RULE1 RULE2

  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] m,
                                          input logic [7:0] d, input logic [7:0] t,
                                          input logic [7:0] s);
    unique case (a)
      ssf_pkg::MAIN_EVENT_ADDR: read_mux = m;
      ssf_pkg::MEAS_DETAIL_ADDR: read_mux = d;
      ssf_pkg::THRESH_CAUSE_ADDR: read_mux = t;
      ssf_pkg::SYS_EVENT_ADDR: read_mux = s;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  wire [7:0] next_rdata = read_mux(reg_addr, main_event_status, measurement_detail_status,
                                   threshold_cause_status, system_event_status);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      main_event_status <= ssf_pkg::RESET_VALUE; // RULE17
      reg_rdata <= ssf_pkg::RESET_VALUE;
      prev_fill <= '0;
      prev_queue_cond <= 1'b0;
    end else begin
      main_event_status <= next_main;
      prev_fill <= queue_fill_level;
      prev_queue_cond <= queue_cond;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // persistence run of consecutive out-of-window measurements
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pers_run <= '0;
    end else if (meas.done) begin
      pers_run <= outside ? pers_inc : 4'h0; // RULE16
    end
  end

  // detail bits follow the most recent measurement
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      measurement_detail_status <= ssf_pkg::RESET_VALUE; // RULE17
    end else if (meas.done) begin
      measurement_detail_status[ssf_pkg::VALID_BIT] <= 1'b1; // RULE10
      measurement_detail_status[ssf_pkg::CNT_SAT_BIT] <= meas.counter_saturation; // RULE11
      measurement_detail_status[ssf_pkg::FE_SAT_BIT] <= meas.frontend_saturation; // RULE12
    end
  end

  // cause bits name the side of the window for the latest threshold event
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      threshold_cause_status <= ssf_pkg::RESET_VALUE;
    end else if (spec_hit) begin
      threshold_cause_status[ssf_pkg::HIGH_BIT] <= above; // RULE13
      threshold_cause_status[ssf_pkg::LOW_BIT] <= below; // RULE14
    end
  end

  // cause stays until the host clears the system flag in the main register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      system_event_status <= ssf_pkg::RESET_VALUE;
    end else if (switch_matrix_done) begin
      system_event_status[ssf_pkg::SENSOR_SWITCH_MATRIX_BIT] <= 1'b1; // RULE15
    end else if (clr_mask[ssf_pkg::SYS_BIT]) begin
      system_event_status[ssf_pkg::SENSOR_SWITCH_MATRIX_BIT] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_w1c_clears;
    @(posedge ref_clk) disable iff (!arst_n)
    (main_wr && reg_wdata[ssf_pkg::SPEC_BIT] && !set_mask[ssf_pkg::SPEC_BIT])
      |=> !main_event_status[ssf_pkg::SPEC_BIT];
  endproperty
  a_w1c_clears: assert property (p_w1c_clears) else $error("w1c did not clear"); // RULE1

  property p_zero_keeps;
    @(posedge ref_clk) disable iff (!arst_n)
    main_wr |=> ((($past(main_event_status) & ~$past(reg_wdata)) & ~main_event_status) == 8'h00);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write lost a flag"); // RULE2

  property p_sat_sets;
    @(posedge ref_clk) disable iff (!arst_n)
    (meas.done && meas.frontend_saturation && cfg.saturation_irq_enable)
      |=> main_event_status[ssf_pkg::SAT_BIT] && measurement_detail_status[ssf_pkg::FE_SAT_BIT];
  endproperty
  a_sat_sets: assert property (p_sat_sets) else $error("saturation not flagged"); // RULE5

  property p_spec_high;
    @(posedge ref_clk) disable iff (!arst_n)
    (spec_hit && above && cfg.spectral_irq_enable)
      |=> main_event_status[ssf_pkg::SPEC_BIT] && threshold_cause_status[ssf_pkg::HIGH_BIT]
          && !threshold_cause_status[ssf_pkg::LOW_BIT];
  endproperty
  a_spec_high: assert property (p_spec_high) else $error("high threshold cause wrong"); // RULE13

  property p_in_window_quiet;
    @(posedge ref_clk) disable iff (!arst_n)
    (!main_event_status[ssf_pkg::SPEC_BIT] && !(meas.done && outside))
      |=> !main_event_status[ssf_pkg::SPEC_BIT];
  endproperty
  a_in_window_quiet: assert property (p_in_window_quiet) else $error("spurious flag"); // RULE16

  property p_queue_reassert;
    @(posedge ref_clk) disable iff (!arst_n)
    (queue_cond && prev_queue_cond && queue_fill_level > prev_fill && cfg.queue_irq_enable)
      |=> main_event_status[ssf_pkg::QUEUE_BIT];
  endproperty
  a_queue_reassert: assert property (p_queue_reassert) else $error("queue flag missed"); // RULE8

  property p_sys_sets;
    @(posedge ref_clk) disable iff (!arst_n)
    (switch_matrix_done && cfg.system_irq_enable)
      |=> main_event_status[ssf_pkg::SYS_BIT] && system_event_status[ssf_pkg::SENSOR_SWITCH_MATRIX_BIT];
  endproperty
  a_sys_sets: assert property (p_sys_sets) else $error("system event not flagged"); // RULE9

  property p_valid;
    @(posedge ref_clk) disable iff (!arst_n)
    meas.done |=> measurement_detail_status[ssf_pkg::VALID_BIT];
  endproperty
  a_valid: assert property (p_valid) else $error("valid bit not set"); // RULE10

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (!arst_n)
    ((main_event_status & ~ssf_pkg::MAIN_MASK) == 8'h00)
      && ((measurement_detail_status & 8'hA7) == 8'h00)
      && ((threshold_cause_status & 8'hCF) == 8'h00)
      && ((system_event_status & 8'hFB) == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // RULE17

  property p_queue_sets;
    @(posedge ref_clk) disable iff (!arst_n)
    (queue_cond && !prev_queue_cond && cfg.queue_irq_enable)
      |=> main_event_status[ssf_pkg::QUEUE_BIT];
  endproperty
  a_queue_sets: assert property (p_queue_sets) else $error("queue flag not raised"); // RULE7

  // enable off must keep the main flag down even when a threshold event fires
  property p_spec_gated;
    @(posedge ref_clk) disable iff (!arst_n)
    (!cfg.spectral_irq_enable && !main_event_status[ssf_pkg::SPEC_BIT])
      |=> !main_event_status[ssf_pkg::SPEC_BIT];
  endproperty
  a_spec_gated: assert property (p_spec_gated) else $error("flag while disabled"); // RULE6

  property p_spec_low;
    @(posedge ref_clk) disable iff (!arst_n)
    (spec_hit && below && cfg.spectral_irq_enable)
      |=> main_event_status[ssf_pkg::SPEC_BIT] && threshold_cause_status[ssf_pkg::LOW_BIT]
          && !threshold_cause_status[ssf_pkg::HIGH_BIT];
  endproperty
  a_spec_low: assert property (p_spec_low) else $error("low threshold cause wrong"); // RULE14

  property p_detail_copy;
    @(posedge ref_clk) disable iff (!arst_n)
    meas.done |=>
      (measurement_detail_status[ssf_pkg::CNT_SAT_BIT] == $past(meas.counter_saturation))
      && (measurement_detail_status[ssf_pkg::FE_SAT_BIT] == $past(meas.frontend_saturation));
  endproperty
  a_detail_copy: assert property (p_detail_copy) else $error("detail wrong"); // RULE11 RULE12

  property p_sys_holds;
    @(posedge ref_clk) disable iff (!arst_n)
    (system_event_status[ssf_pkg::SENSOR_SWITCH_MATRIX_BIT] && !clr_mask[ssf_pkg::SYS_BIT])
      |=> system_event_status[ssf_pkg::SENSOR_SWITCH_MATRIX_BIT];
  endproperty
  a_sys_holds: assert property (p_sys_holds) else $error("switch matrix cause lost"); // RULE15

  c_w1c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    main_event_status[ssf_pkg::SPEC_BIT] ##1 main_wr ##1 !main_event_status[ssf_pkg::SPEC_BIT]);
  c_set_wins: cover property (@(posedge ref_clk) disable iff (!arst_n)
    main_wr && reg_wdata[ssf_pkg::SAT_BIT] && set_mask[ssf_pkg::SAT_BIT]);
  c_low: cover property (@(posedge ref_clk) disable iff (!arst_n) spec_hit && below);
endmodule : ssf_flag_bank

// *** bench/ssf_host_model.sv ***
`timescale 1ns/1ps
module ssf_host_model (
  // clock
  input wire logic ref_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1 reg_rd = 1'b0;
    q = reg_rdata;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
    // released data no longer shows the written byte
    reg_wdata = ~v;
  endtask : wr
  // write back what was read, so later events survive
  task automatic service(output logic [7:0] q);
    rd(ssf_pkg::MAIN_EVENT_ADDR, q);
    wr(ssf_pkg::MAIN_EVENT_ADDR, q);
  endtask : service
endmodule : ssf_host_model

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic ref_clk;
  logic arst_n;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  ssf_pkg::ssf_meas_t meas;
  ssf_pkg::ssf_cfg_t cfg;
  logic [7:0] queue_fill_level;
  logic switch_matrix_done;
  logic [7:0] d;
  int n_errors;
  int total_checks;
  int cyc;
  ssf_flag_bank DUT (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .meas(meas), .cfg(cfg), .queue_fill_level(queue_fill_level),
    .switch_matrix_done(switch_matrix_done));
  ssf_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    total_checks++;
    if (d !== e) begin
      n_errors++;
      $display("[FAIL] reg %h exp %h got %h", a, e, d);
    end
  endtask : chk
  task automatic cmain(input logic [7:0] e);
    chk(ssf_pkg::MAIN_EVENT_ADDR, e);
  endtask : cmain
  task automatic pulse(input logic [15:0] v, input logic cs, input logic fs);
    @(posedge ref_clk);
    #1 meas.value = v;
    meas.counter_saturation = cs;
    meas.frontend_saturation = fs;
    meas.done = 1'b1;
    @(posedge ref_clk);
    #1 meas.done = 1'b0;
  endtask : pulse
  task automatic fill(input logic [7:0] v);
    @(posedge ref_clk);
    #1 queue_fill_level = v;
  endtask : fill
  ////////////////////////////////////////////////////////////////
  task automatic t_sat;
    cfg.saturation_irq_enable = 1'b1;
    pulse(16'h0800, 1'b0, 1'b1);
    cmain(8'h80);
    chk(ssf_pkg::MEAS_DETAIL_ADDR, 8'h48);
    pulse(16'h0800, 1'b1, 1'b0);
    chk(ssf_pkg::MEAS_DETAIL_ADDR, 8'h50);
    host.wr(ssf_pkg::MAIN_EVENT_ADDR, 8'h00);
    cmain(8'h80);
    host.wr(ssf_pkg::MEAS_DETAIL_ADDR, 8'hFF);
    chk(ssf_pkg::MEAS_DETAIL_ADDR, 8'h50);
    // clear and fresh saturation on one edge: the set must win
    fork
      host.wr(ssf_pkg::MAIN_EVENT_ADDR, 8'h80);
      pulse(16'h0800, 1'b0, 1'b1);
    join
    cmain(8'h80);
    host.service(d);
    cmain(8'h00);
    // saturated result dropped; host measures again at a lower gain
    pulse(16'h0400, 1'b0, 1'b0);
    chk(ssf_pkg::MEAS_DETAIL_ADDR, 8'h40);
    $display("t_sat done");
  endtask : t_sat
  // value equal to high is inside, so it must break the run
  task automatic t_spec;
    pulse(16'h2000, 1'b0, 1'b0);
    pulse(16'h2000, 1'b0, 1'b0);
    cmain(8'h00);
    chk(ssf_pkg::THRESH_CAUSE_ADDR, 8'h20);
    cfg.spectral_irq_enable = 1'b1;
    pulse(16'h1000, 1'b0, 1'b0);
    pulse(16'h0050, 1'b0, 1'b0);
    cmain(8'h00);
    pulse(16'h0050, 1'b0, 1'b0);
    cmain(8'h08);
    chk(ssf_pkg::THRESH_CAUSE_ADDR, 8'h10);
    host.service(d);
    cmain(8'h00);
    // run still counts: a result above the window after one below fires at once
    pulse(16'h2000, 1'b0, 1'b0);
    cmain(8'h08);
    chk(ssf_pkg::THRESH_CAUSE_ADDR, 8'h20);
    host.service(d);
    cmain(8'h00);
    $display("t_spec done");
  endtask : t_spec
  task automatic t_queue;
    cfg.queue_threshold = 8'h04;
    cfg.queue_irq_enable = 1'b1;
    fill(8'h03);
    cmain(8'h00);
    fill(8'h04);
    cmain(8'h04);
    host.service(d);
    cmain(8'h00);
    fill(8'h05);
    cmain(8'h04);
    host.service(d);
    fill(8'h00);
    cmain(8'h00);
    $display("t_queue done");
  endtask : t_queue
  task automatic t_sys;
    cfg.system_irq_enable = 1'b1;
    @(posedge ref_clk);
    #1 switch_matrix_done = 1'b1;
    @(posedge ref_clk);
    #1 switch_matrix_done = 1'b0;
    cmain(8'h01);
    chk(ssf_pkg::SYS_EVENT_ADDR, 8'h04);
    chk(8'h92, 8'h00);
    host.service(d);
    chk(ssf_pkg::SYS_EVENT_ADDR, 8'h00);
    $display("t_sys done");
  endtask : t_sys
  // flags raised before a mid-run reset must all be gone after it
  task automatic t_reset;
    @(posedge ref_clk);
    #1 switch_matrix_done = 1'b1;
    @(posedge ref_clk);
    #1 switch_matrix_done = 1'b0;
    cmain(8'h01);
    @(posedge ref_clk);
    #1 arst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    cmain(8'h00);
    chk(ssf_pkg::SYS_EVENT_ADDR, 8'h00);
    chk(ssf_pkg::MEAS_DETAIL_ADDR, 8'h00);
    chk(ssf_pkg::THRESH_CAUSE_ADDR, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    arst_n = 1'b0;
    meas = '0;
    cfg = '0;
    cfg.low_threshold = 16'h0100;
    cfg.high_threshold = 16'h1000;
    cfg.persistence_count = 4'h2;
    queue_fill_level = 8'h00;
    switch_matrix_done = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    cmain(8'h00);
    chk(ssf_pkg::THRESH_CAUSE_ADDR, 8'h00);
    t_sat;
    t_spec;
    t_queue;
    t_sys;
    t_reset;
    close_out;
  end
endmodule : tb_top
